/* File: aluds_defines.vh */
// Shared constants for the ALU and result selector datapath.
`ifndef ALUDS_DEFINES_VH
`define ALUDS_DEFINES_VH

// Datapath geometry: four 4-bit slices make one 16-bit word.
`define ALUDS_DATA_W 16
`define ALUDS_NIB_W 4
`define ALUDS_SLICES 4

// APB geometry.
`define ALUDS_ADDR_W 12
`define ALUDS_PDATA_W 32

// Register byte offsets.
`define ALUDS_CTRL_OFF 12'h000
`define ALUDS_RESULT_OFF 12'h004
`define ALUDS_FLAGS_OFF 12'h008
`define ALUDS_OPER_OFF 12'h00c

// Control register fields and reset value.
`define ALUDS_CTRL_W 7
`define ALUDS_CTRL_RST 7'h00
`define ALUDS_CTRL_FSEL_MSB 3
`define ALUDS_CTRL_FSEL_LSB 0
`define ALUDS_CTRL_MODE 4
`define ALUDS_CTRL_CARRY 5
`define ALUDS_CTRL_ARSEL 6

// Left operand bus source codes.
`define ALUDS_LSRC_SCRATCH 3'h0
`define ALUDS_LSRC_CONST 3'h1
`define ALUDS_LSRC_STATUS 3'h2
`define ALUDS_LSRC_SWITCH 3'h3
`define ALUDS_LSRC_SERIAL 3'h4

// Right operand bus mode codes.
`define ALUDS_RMODE_PLAIN 2'h0
`define ALUDS_RMODE_SIGNX 2'h1
`define ALUDS_RMODE_ONE 2'h2

// Fixed data words.
`define ALUDS_WORD_ONE 16'h0001
`define ALUDS_WORD_ZERO 16'h0000
`define ALUDS_PWORD_ZERO 32'h0000_0000
`define ALUDS_FLAGS_PAD 28'h000_0000

`endif

/* File: aluds_slice.v */
// One 4-bit function-generator slice with conventional select encoding.
`timescale 1ns/1ns
`include "aluds_defines.vh"

module aluds_slice
(
  input wire [`ALUDS_NIB_W-1:0] a_in,
  input wire [`ALUDS_NIB_W-1:0] b_in,
  input wire [`ALUDS_NIB_W-1:0] sel_in,
  input wire mode_in,
  input wire carry_n_in,
  output wire [`ALUDS_NIB_W-1:0] f_out,
  output wire eq_out,
  output wire gen_n_out,
  output wire prop_n_out,
  output wire carry_n_out
);
  // Per-bit inverted propagate and generate terms of the classic slice.
  wire [`ALUDS_NIB_W-1:0] t1;
  wire [`ALUDS_NIB_W-1:0] t2;
  // Active-high internal carries; index 0 is the carry into bit 0.
  wire [`ALUDS_NIB_W:0] c;
  wire [`ALUDS_NIB_W-1:0] g;
  wire [`ALUDS_NIB_W-1:0] p;

  assign t1 = ~(a_in | (b_in & {4{sel_in[0]}}) | (~b_in & {4{sel_in[1]}}));
  assign t2 = ~((a_in & ~b_in & {4{sel_in[2]}}) | (a_in & b_in & {4{sel_in[3]}}));
  assign g = ~t2;
  assign p = ~t1;
  // The carry pin is active low, so a high level means no carry.
  assign c[0] = ~carry_n_in;
  assign c[1] = g[0] | (p[0] & c[0]);
  assign c[2] = g[1] | (p[1] & c[1]);
  assign c[3] = g[2] | (p[2] & c[2]);
  assign c[4] = g[3] | (p[3] & c[3]);
  // Logic mode forces the carry term high, which masks the ripple.
  assign f_out = (t1 ^ t2) ^ (c[3:0] | {4{mode_in}});
  // The carry-free half sum is all ones exactly when the nibbles match
  // under the subtract selection. Using it keeps the flag independent of
  // the carry-in, so equality shows with or without the borrow.
  assign eq_out = &(t1 ^ t2);
  assign prop_n_out = ~(&p);
  assign gen_n_out = ~(g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) |
                      (p[3] & p[2] & p[1] & g[0]));
  assign carry_n_out = ~c[4];
endmodule // aluds_slice

/* File: aluds_carry_la.v */
// Look-ahead carry generator joining four slices.
`timescale 1ns/1ns
`include "aluds_defines.vh"

module aluds_carry_la
(
  input wire [`ALUDS_SLICES-1:0] gen_n_in,
  input wire [`ALUDS_SLICES-1:0] prop_n_in,
  input wire carry_n_in,
  output wire [`ALUDS_SLICES-2:0] carry_n_out
);
  // Active-high group terms and carries; c0 is the word carry in.
  wire [`ALUDS_SLICES-1:0] g;
  wire [`ALUDS_SLICES-1:0] p;
  wire c0;
  wire c1;
  wire c2;
  wire c3;

  assign g = ~gen_n_in;
  assign p = ~prop_n_in;
  assign c0 = ~carry_n_in;
  // Flattened equations avoid a ripple through the slices.
  assign c1 = g[0] | (p[0] & c0);
  assign c2 = g[1] | (p[1] & g[0]) | (p[1] & p[0] & c0);
  assign c3 = g[2] | (p[2] & g[1]) | (p[2] & p[1] & g[0]) |
              (p[2] & p[1] & p[0] & c0);
  assign carry_n_out = ~{c3, c2, c1};
endmodule // aluds_carry_la

/* File: aluds_top.v */
// Top level of the ALU and result selector datapath with its APB port.
`timescale 1ns/1ns
`include "aluds_defines.vh"

module aluds_top
(
  // Processor clock and asynchronous active-low reset.
  input wire clk_in,
  input wire rst_n_in,
  // APB slave port.
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [`ALUDS_ADDR_W-1:0] paddr_in,
  input wire [`ALUDS_PDATA_W-1:0] pwdata_in,
  input wire [3:0] pstrb_in,
  output wire [`ALUDS_PDATA_W-1:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  // Left operand bus sources and their select code.
  input wire [`ALUDS_DATA_W-1:0] scratch_data_in,
  input wire [`ALUDS_DATA_W-1:0] const_data_in,
  input wire [`ALUDS_DATA_W-1:0] status_word_in,
  input wire [`ALUDS_DATA_W-1:0] switch_reg_in,
  input wire [`ALUDS_DATA_W-1:0] serial_data_in,
  input wire [2:0] left_src_sel_in,
  // Right holding register word and right operand bus mode.
  input wire [`ALUDS_DATA_W-1:0] right_holding_in,
  input wire [1:0] right_mode_in,
  // Incoming system-bus data word.
  input wire [`ALUDS_DATA_W-1:0] sysbus_data_in,
  // Function select lines, active low, from three sources.
  input wire [3:0] mc_func_sel_n_in,
  input wire [3:0] aux_func_sel_n_in,
  input wire [3:0] ir_func_sel_n_in,
  // Logic versus arithmetic mode, active high, from three sources.
  input wire mc_mode_in,
  input wire aux_mode_in,
  input wire ir_mode_in,
  // Carry-in requests, active high, from three sources.
  input wire microcode_carry_in,
  input wire aux_carry_in,
  input wire ir_carry_in,
  // Result selector control from microcode.
  input wire select_arith_result_in,
  // Carry-from-status request and stored status carry, both active low.
  input wire carry_from_status_request_n_in,
  input wire status_carry_flag_n_in,
  // Captured result word and flags.
  output wire [`ALUDS_DATA_W-1:0] result_out,
  output wire low_byte_equal_flag_out,
  output wire high_byte_equal_flag_out,
  output wire alu_carry_out,
  output wire slice_carry_input_out
);

  // Pin synchronisers for the inputs that come from off-chip.
  // The first stage of each feeds only the second stage.
  reg [`ALUDS_DATA_W-1:0] sysbus_s1_r;
  reg [`ALUDS_DATA_W-1:0] sysbus_s2_r;
  reg [`ALUDS_DATA_W-1:0] switch_s1_r;
  reg [`ALUDS_DATA_W-1:0] switch_s2_r;
  reg [`ALUDS_DATA_W-1:0] serial_s1_r;
  reg [`ALUDS_DATA_W-1:0] serial_s2_r;

  // Software control word that joins the wired-OR control sources.
  reg [`ALUDS_CTRL_W-1:0] ctrl_r;

  // Captured datapath outputs.
  reg [`ALUDS_DATA_W-1:0] result_r;
  reg low_eq_r;
  reg high_eq_r;
  reg cout_r;
  reg cin_r;

  // APB answer registers.
  reg [`ALUDS_PDATA_W-1:0] prdata_r;
  reg pready_r;
  reg pslverr_r;

  // Combined control lines after the wired OR.
  wire [3:0] func_sel_wired_n;
  wire [3:0] func_sel;
  wire alu_mode;
  wire carry_req;
  wire sel_arith;

  // Carry-in generation terms.
  wire status_carry_term;
  wire slice_carry_input;

  // Operand buses and ALU outputs.
  reg [`ALUDS_DATA_W-1:0] left_operand_bus;
  reg [`ALUDS_DATA_W-1:0] right_operand_bus;
  wire [`ALUDS_DATA_W-1:0] alu_f;
  wire [`ALUDS_SLICES-1:0] slice_eq;
  wire [`ALUDS_SLICES-1:0] slice_gen_n;
  wire [`ALUDS_SLICES-1:0] slice_prop_n;
  wire [`ALUDS_SLICES-1:0] slice_cout_n;
  wire [`ALUDS_SLICES-1:0] slice_cin_n;
  wire [`ALUDS_SLICES-2:0] la_carry_n;

  // Result selector output and per-byte equality.
  wire [`ALUDS_DATA_W-1:0] result_input_selector;
  wire low_byte_equal_flag;
  wire high_byte_equal_flag;

  // APB decode terms.
  wire apb_setup;
  wire apb_access;
  wire addr_ok;
  reg [`ALUDS_PDATA_W-1:0] read_word;

  // True when both equality bits of a byte are set.
  function byte_equal;
    input [1:0] nib_eq;
    begin
      byte_equal = nib_eq[0] & nib_eq[1];
    end
  endfunction

  // True when the offset names a mapped register.
  function is_mapped;
    input [`ALUDS_ADDR_W-1:0] addr;
    begin
      is_mapped = (addr == `ALUDS_CTRL_OFF) ||
                  (addr == `ALUDS_RESULT_OFF) ||
                  (addr == `ALUDS_FLAGS_OFF) ||
                  (addr == `ALUDS_OPER_OFF);
    end
  endfunction

  // Two-stage synchronisers for the off-chip data words.
  // This adds two cycles of latency on the bus, switch and serial paths.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sysbus_s1_r <= `ALUDS_WORD_ZERO;
      sysbus_s2_r <= `ALUDS_WORD_ZERO;
      switch_s1_r <= `ALUDS_WORD_ZERO;
      switch_s2_r <= `ALUDS_WORD_ZERO;
      serial_s1_r <= `ALUDS_WORD_ZERO;
      serial_s2_r <= `ALUDS_WORD_ZERO;
    end
    else
    begin
      sysbus_s1_r <= sysbus_data_in;
      sysbus_s2_r <= sysbus_s1_r;
      switch_s1_r <= switch_reg_in;
      switch_s2_r <= switch_s1_r;
      serial_s1_r <= serial_data_in;
      serial_s2_r <= serial_s1_r;
    end
  end

  // Active-low select lines are wired together: any low line asserts.
  // The software field is active high, so it is inverted to join them.
  assign func_sel_wired_n = mc_func_sel_n_in & aux_func_sel_n_in &
    ir_func_sel_n_in &
    ~ctrl_r[`ALUDS_CTRL_FSEL_MSB:`ALUDS_CTRL_FSEL_LSB];

  // Buffer inversion turns the wired lines into active-high selects.
  assign func_sel = ~func_sel_wired_n;

  // Mode goes straight to the slices, merged from every source.
  assign alu_mode = mc_mode_in | aux_mode_in | ir_mode_in |
    ctrl_r[`ALUDS_CTRL_MODE];

  // Carry-in requests merge the same way as the other controls.
  assign carry_req = microcode_carry_in | aux_carry_in | ir_carry_in |
    ctrl_r[`ALUDS_CTRL_CARRY];

  // Result selector control; the upper select is permanently low.
  assign sel_arith = select_arith_result_in | ctrl_r[`ALUDS_CTRL_ARSEL];

  // NOR of two active-low lines: high only when both are asserted.
  assign status_carry_term = ~(carry_from_status_request_n_in |
    status_carry_flag_n_in);

  // The merged carry request is flipped by the status carry term.
  assign slice_carry_input = carry_req ^ status_carry_term;

  // Left operand bus source selection.
  // An unused code yields zero rather than a stale source.
  always @*
  begin
    case (left_src_sel_in)
      `ALUDS_LSRC_SCRATCH: left_operand_bus = scratch_data_in;
      `ALUDS_LSRC_CONST: left_operand_bus = const_data_in;
      `ALUDS_LSRC_STATUS: left_operand_bus = status_word_in;
      `ALUDS_LSRC_SWITCH: left_operand_bus = switch_s2_r;
      `ALUDS_LSRC_SERIAL: left_operand_bus = serial_s2_r;
      default: left_operand_bus = `ALUDS_WORD_ZERO;
    endcase
  end

  // Right operand bus: holding word, sign-extended low byte, one, or zero.
  always @*
  begin
    case (right_mode_in)
      `ALUDS_RMODE_PLAIN: right_operand_bus = right_holding_in;
      `ALUDS_RMODE_SIGNX:
        right_operand_bus = {{8{right_holding_in[7]}},
                             right_holding_in[7:0]};
      `ALUDS_RMODE_ONE: right_operand_bus = `ALUDS_WORD_ONE;
      default: right_operand_bus = `ALUDS_WORD_ZERO;
    endcase
  end

  // Slice 0 takes the word carry; the rest take look-ahead carries.
  assign slice_cin_n = {la_carry_n, slice_carry_input};

  // Four function-generator slices make the 16-bit ALU.
  genvar gi;
  generate
    for (gi = 0; gi < `ALUDS_SLICES; gi = gi + 1)
    begin : g_slice
      aluds_slice u_slice
      (
        .a_in(left_operand_bus[gi*4 +: 4]),
        .b_in(right_operand_bus[gi*4 +: 4]),
        .sel_in(func_sel),
        .mode_in(alu_mode),
        .carry_n_in(slice_cin_n[gi]),
        .f_out(alu_f[gi*4 +: 4]),
        .eq_out(slice_eq[gi]),
        .gen_n_out(slice_gen_n[gi]),
        .prop_n_out(slice_prop_n[gi]),
        .carry_n_out(slice_cout_n[gi])
      );
    end
  endgenerate

  // Look-ahead generator shares the word carry with slice 0.
  aluds_carry_la u_carry_la
  (
    .gen_n_in(slice_gen_n),
    .prop_n_in(slice_prop_n),
    .carry_n_in(slice_carry_input),
    .carry_n_out(la_carry_n)
  );

  // Selector: high passes the ALU word, low passes bus data.
  assign result_input_selector = sel_arith ? alu_f :
    sysbus_s2_r;

  // Per-byte AND of the slice equality outputs.
  assign low_byte_equal_flag = byte_equal(slice_eq[1:0]);
  assign high_byte_equal_flag = byte_equal(slice_eq[3:2]);

  // Capture of the settled combinational results on every clock edge.
  // The whole path from operands to selector must fit one period.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      result_r <= `ALUDS_WORD_ZERO;
      low_eq_r <= 1'b0;
      high_eq_r <= 1'b0;
      cout_r <= 1'b0;
      cin_r <= 1'b0;
    end
    else
    begin
      result_r <= result_input_selector;
      low_eq_r <= low_byte_equal_flag;
      high_eq_r <= high_byte_equal_flag;
      cout_r <= ~slice_cout_n[`ALUDS_SLICES-1];
      cin_r <= slice_carry_input;
    end
  end

  // APB phase decode.
  assign apb_setup = psel_in & ~penable_in;
  assign apb_access = psel_in & penable_in & pready_r;
  assign addr_ok = is_mapped(paddr_in);

  // Read data chosen from the current state during the setup cycle.
  always @*
  begin
    case (paddr_in)
      `ALUDS_CTRL_OFF:
        read_word = {{(`ALUDS_PDATA_W-`ALUDS_CTRL_W){1'b0}}, ctrl_r};
      `ALUDS_RESULT_OFF:
        read_word = {`ALUDS_WORD_ZERO, result_r};
      `ALUDS_FLAGS_OFF:
        read_word = {`ALUDS_FLAGS_PAD, cin_r, cout_r, high_eq_r, low_eq_r};
      `ALUDS_OPER_OFF:
        read_word = {right_operand_bus, left_operand_bus};
      default:
        read_word = `ALUDS_PWORD_ZERO;
    endcase
  end

  // APB slave: one access cycle, answer prepared at the setup edge.
  // Unmapped offsets read zero, ignore writes and raise the error flag.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `ALUDS_PWORD_ZERO;
    end
    else
    begin
      pready_r <= apb_setup;
      if (apb_setup)
      begin
        pslverr_r <= ~addr_ok;
        if (!pwrite_in)
        begin
          prdata_r <= read_word;
        end
        else
        begin
          prdata_r <= `ALUDS_PWORD_ZERO;
        end
      end
      else if (apb_access)
      begin
        // The error flag falls with the end of the access.
        pslverr_r <= 1'b0;
      end
    end
  end

  // Control register write, taken only at the completing access edge.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_r <= `ALUDS_CTRL_RST;
    end
    else if (apb_access && pwrite_in && pstrb_in[0] &&
             (paddr_in == `ALUDS_CTRL_OFF))
    begin
      ctrl_r <= pwdata_in[`ALUDS_CTRL_W-1:0];
    end
  end

  // Every output comes straight from a flip-flop.
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign result_out = result_r;
  assign low_byte_equal_flag_out = low_eq_r;
  assign high_byte_equal_flag_out = high_eq_r;
  assign alu_carry_out = cout_r;
  assign slice_carry_input_out = cin_r;

endmodule // aluds_top

/* File: aluds_top_properties.sv */
// Checker of the ALU datapath and its register port, seen at the top ports.
`timescale 1ns/1ns

module aluds_top_checker
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [15:0] scratch_data_in,
  input wire logic [15:0] const_data_in,
  input wire logic [15:0] status_word_in,
  input wire logic [2:0] left_src_sel_in,
  input wire logic [15:0] right_holding_in,
  input wire logic [1:0] right_mode_in,
  input wire logic [15:0] sysbus_data_in,
  input wire logic [3:0] mc_func_sel_n_in,
  input wire logic [3:0] aux_func_sel_n_in,
  input wire logic [3:0] ir_func_sel_n_in,
  input wire logic mc_mode_in,
  input wire logic aux_mode_in,
  input wire logic ir_mode_in,
  input wire logic microcode_carry_in,
  input wire logic aux_carry_in,
  input wire logic ir_carry_in,
  input wire logic select_arith_result_in,
  input wire logic carry_from_status_request_n_in,
  input wire logic status_carry_flag_n_in,
  input wire logic [15:0] result_out,
  input wire logic low_byte_equal_flag_out,
  input wire logic high_byte_equal_flag_out,
  input wire logic slice_carry_input_out
);
  logic [6:0] ctl_r; // Shadow of the control register.
  logic [1:0] up_r; // Edges since reset, saturating at three.
  logic [3:0] s_e; // Effective function selects.
  logic m_e, sel_e, sc_e, sub_e, f_ok;
  logic [15:0] a_v, b_v, f_v;
  wire bad = |paddr_in[11:4] || |paddr_in[1:0]; // Unmapped address.

  // The shadow lets the expected ALU word include register overrides.
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      ctl_r <= 7'h00;
      up_r <= 2'h0;
    end
    else
    begin
      if (up_r != 2'h3)
        up_r <= up_r + 2'h1;
      if (psel_in && penable_in && pready_out && pwrite_in && !bad &&
          paddr_in[3:2] == 2'h0 && pstrb_in[0])
        ctl_r <= pwdata_in[6:0];
    end

  // Reference ALU; only sources seen on the same clock are modelled.
  always_comb
  begin
    s_e = ~(mc_func_sel_n_in & aux_func_sel_n_in & ir_func_sel_n_in) |
      ctl_r[3:0];
    m_e = mc_mode_in | aux_mode_in | ir_mode_in | ctl_r[4];
    sel_e = select_arith_result_in | ctl_r[6];
    sc_e = (microcode_carry_in | aux_carry_in | ir_carry_in | ctl_r[5]) ^
      (!carry_from_status_request_n_in && !status_carry_flag_n_in);
    a_v = left_src_sel_in == 3'h0 ? scratch_data_in :
      left_src_sel_in == 3'h1 ? const_data_in : status_word_in;
    case (right_mode_in)
      2'h0: b_v = right_holding_in;
      2'h1: b_v = {{8{right_holding_in[7]}}, right_holding_in[7:0]};
      2'h2: b_v = 16'h0001;
      default: b_v = 16'h0000;
    endcase
    sub_e = !m_e && s_e == 4'h6 && left_src_sel_in < 3'h3;
    f_ok = left_src_sel_in < 3'h3;
    f_v = 16'h0000;
    case ({m_e, s_e})
      5'h09: f_v = a_v + b_v + {15'h0000, !sc_e};
      5'h06: f_v = a_v - b_v - {15'h0000, sc_e};
      5'h10: f_v = ~a_v;
      5'h19: f_v = ~(a_v ^ b_v);
      5'h1b: f_v = a_v & b_v;
      5'h1e: f_v = a_v | b_v;
      5'h1f: f_v = a_v;
      default: f_ok = 1'b0;
    endcase
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_CARRY: assert property (
    1'b1 |=> slice_carry_input_out == $past(sc_e))
    else $error("slice carry input wrong");
  AST_BUS: assert property (
    !sel_e && up_r == 2'h3 |=> result_out == $past(sysbus_data_in, 3))
    else $error("bus word not passed");
  AST_ALU: assert property (
    sel_e && f_ok |=> result_out == $past(f_v))
    else $error("alu word wrong");
  AST_EQ: assert property (
    sub_e |=> {high_byte_equal_flag_out, low_byte_equal_flag_out} ==
      $past({a_v[15:8] == b_v[15:8], a_v[7:0] == b_v[7:0]}))
    else $error("byte equal flags wrong");
  AST_READY: assert property (
    psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  AST_ONE: assert property (
    pready_out |=> !pready_out)
    else $error("ready held too long");
  AST_SLVERR: assert property (
    psel_in && !penable_in && bad |=> pslverr_out && prdata_out == 0)
    else $error("unmapped access not refused");
  AST_NOERR: assert property (
    psel_in && !penable_in && !bad |=> !pslverr_out)
    else $error("mapped access refused");
  AST_RDRES: assert property (
    psel_in && !penable_in && !pwrite_in && paddr_in == 12'h004 |=>
      prdata_out == {16'h0000, $past(result_out)})
    else $error("result read wrong");
endmodule // aluds_top_checker

bind aluds_top aluds_top_checker u_aluds_top_checker (.*);

/* File: aluds_cstore.sv */
// Model of the control store that drives the ALU control lines.
`timescale 1ns/1ns

module aluds_cstore
(
  input wire logic [3:0] fsel_in,
  input wire logic mode_in,
  input wire logic carry_in,
  input wire logic arith_in,
  output logic [3:0] func_sel_n_out,
  output logic mode_out,
  output logic carry_out,
  output logic arith_out
);
  // An idle word leaves its select lines high, so the other wired-OR
  // sources can still assert a function.
  always_comb
  begin
    func_sel_n_out = ~fsel_in;
    mode_out = mode_in;
    carry_out = carry_in;
    arith_out = arith_in;
  end
endmodule // aluds_cstore

/* File: aluds_top_tb_top.sv */
// Self-checking bench for the ALU and result selector datapath.
`timescale 1ns/1ns

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", n, e, g); end end

module aluds_top_tb_top;
  logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out;
  logic pslverr_out, mc_mode_in, aux_mode_in, ir_mode_in, aux_carry_in;
  logic ir_carry_in, microcode_carry_in, select_arith_result_in;
  logic carry_from_status_request_n_in, status_carry_flag_n_in;
  logic low_byte_equal_flag_out, high_byte_equal_flag_out, alu_carry_out;
  logic slice_carry_input_out, mode, cry, arith;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [3:0] pstrb_in, mc_func_sel_n_in, aux_func_sel_n_in, fsel;
  logic [3:0] ir_func_sel_n_in;
  logic [15:0] scratch_data_in, const_data_in, status_word_in;
  logic [15:0] switch_reg_in, serial_data_in, right_holding_in;
  logic [15:0] sysbus_data_in, result_out;
  logic [2:0] left_src_sel_in;
  logic [1:0] right_mode_in;
  logic err;
  int miscompares, num_checks, i;
  // Distinct words on the five left sources.
  logic [15:0] lv [5] = '{16'h1234, 16'h0002, 16'h8001, 16'h00f0, 16'h5a5a};
  logic [3:0] lgs [5] = '{4'h0, 4'h9, 4'hb, 4'he, 4'hf};
  logic [15:0] rhs [3] = '{16'h5534, 16'h1234, 16'h1235};
  logic [1:0] eqs [3] = '{2'h1, 2'h3, 2'h2};

  aluds_top u_aluds_top (.*);

  aluds_cstore u_aluds_cstore
  (
    .fsel_in(fsel),
    .mode_in(mode),
    .carry_in(cry),
    .arith_in(arith),
    .func_sel_n_out(mc_func_sel_n_in),
    .mode_out(mc_mode_in),
    .carry_out(microcode_carry_in),
    .arith_out(select_arith_result_in)
  );

  // Free-running 25 MHz processor clock.
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Right operand bus word expected for each mode.
  function automatic [15:0] rv(input [1:0] rm);
    rv = rm == 2'h0 ? right_holding_in : rm == 2'h1 ?
      {{8{right_holding_in[7]}}, right_holding_in[7:0]} :
      {15'h0000, rm == 2'h2};
  endfunction

  // Logic-mode results for the functions the microprogram uses.
  function automatic [15:0] lg(input [3:0] s, input [15:0] a, b);
    case (s)
      4'h0: lg = ~a;
      4'h9: lg = ~(a ^ b);
      4'hb: lg = a & b;
      4'he: lg = a | b;
      default: lg = a;
    endcase
  endfunction

  // Three edges cover the synchroniser on the pin sources as well.
  task automatic run(input [2:0] ls, input [1:0] rm, input [3:0] s,
    input m, c, sa, input [15:0] e);
    @(posedge clk_in);
    left_src_sel_in <= ls;
    right_mode_in <= rm;
    {fsel, mode, cry, arith} <= {s, m, c, sa};
    repeat (3) @(posedge clk_in);
    #1 `CHK("result", e, result_out)
  endtask

  // One bus transfer; the request is held until ready is seen high.
  task automatic apb(input w, input [11:0] a, input [31:0] d);
    int k;
    @(posedge clk_in);
    {psel_in, penable_in, pwrite_in} <= {2'h2, w};
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (k = 0; k < 8 && pready_out !== 1'b1; k++)
      @(posedge clk_in);
    if (k == 8)
    begin
      miscompares++;
      close_out();
    end
    {rd, err} = {prdata_out, pslverr_out};
    {psel_in, penable_in} <= 2'h0;
  endtask

  // Prints the verdict and ends the run.
  task automatic close_out;
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence of scenarios.
  initial
  begin
    {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in} = 16'h0000;
    {pwdata_in, pstrb_in} = {32'h0000_0000, 4'hf};
    {scratch_data_in, const_data_in, status_word_in} = {lv[0], lv[1], lv[2]};
    {switch_reg_in, serial_data_in} = {lv[3], lv[4]};
    {left_src_sel_in, right_mode_in} = 5'h00;
    {right_holding_in, sysbus_data_in} = {16'h0080, 16'h0000};
    {aux_func_sel_n_in, ir_func_sel_n_in} = 8'hff;
    {aux_mode_in, ir_mode_in, aux_carry_in, ir_carry_in} = 4'h0;
    {carry_from_status_request_n_in, status_carry_flag_n_in} = 2'h3;
    {fsel, mode, cry, arith} = 7'h00;
    {miscompares, num_checks} = 0;
    repeat (4) @(posedge clk_in);
    #1 `CHK("reset result", 16'h0000, result_out)
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK("ctrl reset", 32'h0000_0000, rd)
    for (i = 0; i < 20; i++)
    begin
      run(3'(i / 4), 2'(i % 4), 4'h9, 1'b0, 1'b1, 1'b1,
        lv[i / 4] + rv(2'(i % 4)));
      `CHK("carry out", 17'(lv[i / 4]) + 17'(rv(2'(i % 4))) >> 16,
        alu_carry_out)
    end
    for (i = 0; i < 5; i++)
      run(3'h2, 2'h1, lgs[i], 1'b1, 1'b0, 1'b1,
        lg(lgs[i], lv[2], rv(2'h1)));
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk_in);
      right_holding_in <= rhs[i];
      run(3'h0, 2'h0, 4'h6, 1'b0, 1'b0, 1'b1, lv[0] - rhs[i]);
      `CHK("eq flags", eqs[i], {high_byte_equal_flag_out,
        low_byte_equal_flag_out})
    end
    run(3'h0, 2'h0, 4'h6, 1'b0, 1'b1, 1'b1,
      lv[0] - rhs[2] - 16'h0001);
    for (i = 0; i < 32; i++)
    begin
      @(posedge clk_in);
      {ir_carry_in, aux_carry_in, status_carry_flag_n_in} <= 3'(i >> 2);
      {carry_from_status_request_n_in, cry} <= 2'(i);
      @(posedge clk_in);
      #1 `CHK("slice carry", (i[0] | i[3] | i[4]) ^ (!i[1] && !i[2]),
        slice_carry_input_out)
    end
    @(posedge clk_in);
    {aux_func_sel_n_in, ir_carry_in, aux_carry_in} <= 6'h24;
    {carry_from_status_request_n_in, status_carry_flag_n_in} <= 2'h3;
    run(3'h0, 2'h2, 4'h0, 1'b0, 1'b0, 1'b1, lv[0] - 16'h0001);
    @(posedge clk_in);
    {aux_func_sel_n_in, ir_func_sel_n_in, aux_mode_in} <= 9'h1e9;
    run(3'h1, 2'h2, 4'h0, 1'b0, 1'b0, 1'b1, 16'h0000);
    @(posedge clk_in);
    {ir_func_sel_n_in, aux_mode_in, sysbus_data_in} <= {5'h1e, 16'hbeef};
    run(3'h0, 2'h0, 4'h0, 1'b0, 1'b0, 1'b0, 16'hbeef);
    apb(1'b1, 12'h000, 32'h0000_0049);
    run(3'h1, 2'h2, 4'h0, 1'b0, 1'b0, 1'b0, 16'h0004);
    apb(1'b1, 12'h004, 32'hffff_ffff);
    `CHK("ro write err", 1'b0, err)
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("result read", 32'h0000_0004, rd)
    apb(1'b0, 12'h00c, 32'h0000_0000);
    `CHK("operands", 32'h0001_0002, rd)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    apb(1'b1, 12'h000, 32'hffff_ffff);
    apb(1'b0, 12'h000, 32'h0000_0000);
    `CHK("ctrl rw", 32'h0000_007f, rd)
    close_out();
  end
endmodule // aluds_top_tb_top
